// [sas_analog_model.sv]
`default_nettype none
module sas_analog_model
    import sas_pkg::*;
(
    input wire logic sys_clk_in,
    input wire sas_pkg::sas_analog_type analog_in,
    input wire logic [9:0] base_in,
    output logic comparator_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] held_reg = 10'h000;
    logic flip_reg = 1'b0;
    always_ff @(posedge sys_clk_in) begin
        flip_reg <= ~flip_reg;
        if (analog_in.sample) begin
            held_reg <= base_in + 10'(analog_in.channel) * 10'h047;
        end
    end
    // Outside hold the output means nothing, so it toggles
    assign comparator_out = analog_in.hold ?
        (held_reg >= analog_in.dac_code) : flip_reg;
endmodule
`default_nettype wire

// [sas_assertions.sv]
`default_nettype none
module sas_assertions
    import sas_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire sas_pkg::sas_bus_req_type bus_req_in,
    input wire logic [7:0] bus_rdata_out,
    input wire sas_pkg::sas_analog_type analog_out,
    input wire logic conv_end_irq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SAMPLE_C = SAMPLE_CYCLES;
    logic [7:0] samp_cnt_reg;
    logic [7:0] thresh_reg;
    // Length of the current sampling run
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            samp_cnt_reg <= 8'h00;
        end else begin
            samp_cnt_reg <= analog_out.sample ? samp_cnt_reg + 8'h01 : 8'h00;
        end
    end
    // Shadow of the compare threshold
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            thresh_reg <= REG_RESET;
        end else if (bus_req_in.wr && bus_req_in.addr == ADDR_CMP_THRESH) begin
            thresh_reg <= bus_req_in.wdata;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_sample_end;
        analog_out.sample ##1 !analog_out.sample;
    endsequence
    sequence s_hold_start;
        !analog_out.hold ##1 analog_out.hold;
    endsequence
    a_sample_hold_excl: assert property (!(analog_out.sample && analog_out.hold))
        else $error("sample and hold active together");
    a_sample_then_hold: assert property (s_sample_end |-> analog_out.hold)
        else $error("hold did not follow sampling");
    a_sample_length: assert property (s_hold_start |-> samp_cnt_reg == 8'(SAMPLE_C))
        else $error("sampling period length wrong");
    a_first_trial_code: assert property (
        s_hold_start |-> (analog_out.dac_code == 10'h200) [*8])
        else $error("first trial code wrong");
    a_channel_steady: assert property (
        analog_out.hold && $past(analog_out.hold) |-> $stable(analog_out.channel))
        else $error("channel changed during hold");
    a_irq_one_cycle: assert property (conv_end_irq_out |=> !conv_end_irq_out)
        else $error("interrupt longer than one cycle");
    a_irq_after_trials: assert property (
        conv_end_irq_out |-> $past(analog_out.hold) || $past(analog_out.hold, 2))
        else $error("interrupt without finished trials");
    a_rdata_idle: assert property (!$past(bus_req_in.rd) |-> bus_rdata_out == 8'h00)
        else $error("read data outside read answer");
    a_thresh_readback: assert property (
        $past(bus_req_in.rd) && $past(bus_req_in.addr) == ADDR_CMP_THRESH
        |-> bus_rdata_out == thresh_reg)
        else $error("threshold read back wrong");
endmodule
bind sas_sequencer sas_assertions sas_assertions_i (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .bus_req_in(bus_req_in),
    .bus_rdata_out(bus_rdata_out),
    .analog_out(analog_out),
    .conv_end_irq_out(conv_end_irq_out)
);
`default_nettype wire

// [sas_pkg.sv]
`default_nettype none
package sas_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_MODE_A = 4'h0;
    localparam logic [3:0] ADDR_MODE_B = 4'h1;
    localparam logic [3:0] ADDR_TRIG_SRC = 4'h2;
    localparam logic [3:0] ADDR_CHAN_SEL = 4'h3;
    localparam logic [3:0] ADDR_CMP_MODE = 4'h4;
    localparam logic [3:0] ADDR_CMP_THRESH = 4'h5;
    localparam logic [3:0] ADDR_RESULT_IDX = 4'h6;
    localparam logic [3:0] ADDR_RESULT_LO = 4'h7;
    localparam logic [3:0] ADDR_RESULT_HI = 4'h8;
    localparam logic [3:0] ADDR_RESULT_BYTE = 4'h9;
    localparam logic [3:0] ADDR_STATUS = 4'hA;
    // Field positions in mode_reg_a
    localparam int MA_CONV_ENABLE = 7;
    localparam int MA_CONV_ACTIVE = 6;
    localparam int MA_OP_MODE_HI = 5;
    localparam int MA_OP_MODE_LO = 4;
    localparam int MA_EDGE_HI = 3;
    localparam int MA_EDGE_LO = 2;
    localparam int MA_HW_TRIG = 0;
    // Field positions in compare_mode_reg
    localparam int CM_ENABLE = 7;
    localparam int CM_DIRECTION = 6;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int RESULT_BITS = 10;
    localparam int NUM_CHANNELS = 12;
    localparam logic [3:0] LAST_CHANNEL = 4'hB;
    localparam logic [3:0] MSB_INDEX = 4'h9;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int SAMPLE_NS = 250;
    localparam int TRIAL_NS = 100;
    localparam int TRIG_DELAY_NS = 15;
    localparam int SAMPLE_CYCLES = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
    localparam int TRIAL_CYCLES = (TRIAL_NS * CLK_MHZ + 999) / 1000;
    localparam int TRIG_DELAY_CYCLES = (TRIG_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_CYCLES - 1);
    localparam logic [7:0] TRIAL_LAST = 8'(TRIAL_CYCLES - 1);
    localparam logic [7:0] TRIG_DELAY_LAST = 8'(TRIG_DELAY_CYCLES - 1);
    // Trigger sources and edges
    localparam logic [1:0] SRC_EXT_PIN = 2'h0;
    localparam logic [1:0] SRC_TIMER0 = 2'h1;
    localparam logic [1:0] SRC_TIMER1 = 2'h2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    typedef enum logic [1:0] {
        OP_CONT_SELECT,
        OP_CONT_SCAN,
        OP_ONE_SELECT,
        OP_ONE_SCAN
    } sas_op_mode_type;
    typedef enum {
        ST_IDLE,
        ST_WAIT_TRIG,
        ST_TRIG_DELAY,
        ST_SAMPLE,
        ST_TRIAL
    } sas_state_type;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sas_bus_req_type;
    typedef struct packed {
        logic sample;
        logic hold;
        logic [3:0] channel;
        logic [9:0] dac_code;
    } sas_analog_type;
endpackage
`default_nettype wire

// [sas_sequencer.sv]
// Our own choices: strobed register access and the placing of the registers.
`default_nettype none
module sas_sequencer
    import sas_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire sas_pkg::sas_bus_req_type bus_req_in,
    output logic [7:0] bus_rdata_out,
    input wire logic ext_trigger_pin_in,
    input wire logic timer_match0_req_in,
    input wire logic timer_match1_req_in,
    input wire logic comparator_in,
    output sas_pkg::sas_analog_type analog_out,
    output logic conv_end_irq_out
);
    import sas_pkg::*;

    logic [7:0] mode_reg_a_reg;
    logic [7:0] mode_reg_b_reg;
    logic [7:0] trigger_source_reg;
    logic [7:0] channel_select_reg;
    logic [7:0] compare_mode_reg;
    logic [7:0] compare_threshold_reg;
    logic [3:0] result_idx_reg;
    logic [9:0] result_mem [NUM_CHANNELS];
    sas_state_type state_reg;
    logic [9:0] sar_reg;
    logic [3:0] bit_reg;
    logic [7:0] timer_reg;
    logic [3:0] chan_reg;
    logic active_reg;
    logic irq_reg;
    logic [7:0] rdata_reg;
    logic [1:0] pin_sync_reg;
    logic [1:0] tm0_sync_reg;
    logic [1:0] tm1_sync_reg;
    logic pin_prev_reg;
    logic tm0_prev_reg;
    logic tm1_prev_reg;
    logic cmp_sync_a_reg;
    logic cmp_sync_reg;

    logic conv_enable;
    logic hw_mode;
    logic [1:0] trig_source;
    logic [1:0] edge_select;
    sas_op_mode_type op_mode;
    logic scan_mode;
    logic one_shot;
    logic [3:0] sel_chan;
    logic ctrl_write;
    logic enable_rise;
    logic pin_rise;
    logic pin_fall;
    logic hw_trigger;
    logic converting;
    logic trial_done;
    logic conv_done;
    logic [9:0] sar_final;
    logic last_of_sweep;
    logic cmp_pass;
    logic [3:0] rd_idx;
    logic enable_fall;
    logic stop_req;
    logic restart_req;
    logic tm0_rise;
    logic tm1_rise;
    logic sample_done;
    logic delay_done;
    logic store_en;
    logic [3:0] conv_chan;

    assign conv_enable = mode_reg_a_reg[MA_CONV_ENABLE];
    assign hw_mode = mode_reg_a_reg[MA_HW_TRIG];
    assign trig_source = trigger_source_reg[1:0];
    assign edge_select = {mode_reg_a_reg[MA_EDGE_HI], mode_reg_a_reg[MA_EDGE_LO]};
    assign op_mode = sas_op_mode_type'({mode_reg_a_reg[MA_OP_MODE_HI],
                                        mode_reg_a_reg[MA_OP_MODE_LO]});
    assign scan_mode = (op_mode == OP_CONT_SCAN) || (op_mode == OP_ONE_SCAN);
    assign one_shot = (op_mode == OP_ONE_SELECT) || (op_mode == OP_ONE_SCAN);
    assign sel_chan = channel_select_reg[3:0];
    assign converting = (state_reg == ST_SAMPLE) || (state_reg == ST_TRIAL);
    assign rd_idx = (result_idx_reg > LAST_CHANNEL) ? 4'h0 : result_idx_reg;

    // Writes that disturb a running conversion
    always_comb begin
        ctrl_write = 1'b0;
        if (bus_req_in.wr) begin
            case (bus_req_in.addr)
                ADDR_MODE_A, ADDR_TRIG_SRC, ADDR_CHAN_SEL,
                ADDR_CMP_MODE, ADDR_CMP_THRESH: ctrl_write = 1'b1;
                default: ctrl_write = 1'b0;
            endcase
        end
    end

    assign enable_rise = ctrl_write && (bus_req_in.addr == ADDR_MODE_A) &&
                         bus_req_in.wdata[MA_CONV_ENABLE] && !conv_enable;

    assign enable_fall = ctrl_write && (bus_req_in.addr == ADDR_MODE_A) &&
                         !bus_req_in.wdata[MA_CONV_ENABLE] && conv_enable;
    // Clearing the enable mid-conversion stops rather than restarts
    assign stop_req = (!conv_enable && !enable_rise) || enable_fall;
    assign restart_req = enable_rise || (converting && ctrl_write);

    // Trigger inputs from outside pass two flip-flops
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pin_sync_reg <= 2'h0;
            tm0_sync_reg <= 2'h0;
            tm1_sync_reg <= 2'h0;
            pin_prev_reg <= 1'b0;
            tm0_prev_reg <= 1'b0;
            tm1_prev_reg <= 1'b0;
            cmp_sync_a_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], ext_trigger_pin_in};
            tm0_sync_reg <= {tm0_sync_reg[0], timer_match0_req_in};
            tm1_sync_reg <= {tm1_sync_reg[0], timer_match1_req_in};
            pin_prev_reg <= pin_sync_reg[1];
            tm0_prev_reg <= tm0_sync_reg[1];
            tm1_prev_reg <= tm1_sync_reg[1];
            cmp_sync_a_reg <= comparator_in;
            cmp_sync_reg <= cmp_sync_a_reg;
        end
    end

    assign pin_rise = pin_sync_reg[1] && !pin_prev_reg;
    assign pin_fall = !pin_sync_reg[1] && pin_prev_reg;

    // Timer match requests act on their rising edge
    assign tm0_rise = tm0_sync_reg[1] && !tm0_prev_reg;
    assign tm1_rise = tm1_sync_reg[1] && !tm1_prev_reg;

    // Trigger source and edge selection
    always_comb begin
        hw_trigger = 1'b0;
        case (trig_source)
            SRC_EXT_PIN: begin
                case (edge_select)
                    EDGE_FALL: hw_trigger = pin_fall;
                    EDGE_RISE: hw_trigger = pin_rise;
                    default: hw_trigger = pin_rise || pin_fall;
                endcase
            end
            SRC_TIMER0: hw_trigger = tm0_rise;
            SRC_TIMER1: hw_trigger = tm1_rise;
            default: hw_trigger = 1'b0;
        endcase
        hw_trigger = hw_trigger && hw_mode && conv_enable;
    end

    assign trial_done = (state_reg == ST_TRIAL) && (timer_reg == TRIAL_LAST);
    assign sample_done = (state_reg == ST_SAMPLE) && (timer_reg == SAMPLE_LAST);
    assign delay_done = (state_reg == ST_TRIG_DELAY) && (timer_reg == TRIG_DELAY_LAST);
    assign conv_done = trial_done && (bit_reg == 4'h0);
    assign sar_final = cmp_sync_reg ? sar_reg : (sar_reg & ~(10'h001 << bit_reg));
    assign last_of_sweep = !scan_mode || (chan_reg >= sel_chan);

    // Completion not cut short by a control write or a retrigger
    assign store_en = conv_done && !ctrl_write && !hw_trigger;
    assign conv_chan = scan_mode ? chan_reg : sel_chan;

    always_comb begin
        cmp_pass = 1'b1;
        if (compare_mode_reg[CM_ENABLE]) begin
            if (compare_mode_reg[CM_DIRECTION]) begin
                cmp_pass = sar_final[9:2] < compare_threshold_reg;
            end else begin
                cmp_pass = sar_final[9:2] >= compare_threshold_reg;
            end
        end
    end

    // Register writes
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            mode_reg_a_reg <= REG_RESET;
            mode_reg_b_reg <= REG_RESET;
            trigger_source_reg <= REG_RESET;
            channel_select_reg <= REG_RESET;
            compare_mode_reg <= REG_RESET;
            compare_threshold_reg <= REG_RESET;
            result_idx_reg <= 4'h0;
        end else begin
            if (bus_req_in.wr) begin
                case (bus_req_in.addr)
                    ADDR_MODE_A: mode_reg_a_reg <= bus_req_in.wdata &
                                                   ~(8'h01 << MA_CONV_ACTIVE);
                    ADDR_MODE_B: mode_reg_b_reg <= bus_req_in.wdata;
                    ADDR_TRIG_SRC: trigger_source_reg <= {6'h00, bus_req_in.wdata[1:0]};
                    ADDR_CHAN_SEL: channel_select_reg <= {4'h0, bus_req_in.wdata[3:0]};
                    ADDR_CMP_MODE: compare_mode_reg <= bus_req_in.wdata & 8'hC0;
                    ADDR_CMP_THRESH: compare_threshold_reg <= bus_req_in.wdata;
                    ADDR_RESULT_IDX: result_idx_reg <= bus_req_in.wdata[3:0];
                    default: ;
                endcase
            end
            // One-shot in software mode clears enable on completion
            if (store_en && !hw_mode && one_shot && last_of_sweep) begin
                mode_reg_a_reg[MA_CONV_ENABLE] <= 1'b0;
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
            sar_reg <= 10'h000;
            bit_reg <= MSB_INDEX;
            timer_reg <= 8'h00;
            chan_reg <= 4'h0;
            active_reg <= 1'b0;
        end else if (stop_req) begin
            state_reg <= ST_IDLE;
            sar_reg <= 10'h000;
            bit_reg <= MSB_INDEX;
            timer_reg <= 8'h00;
            chan_reg <= 4'h0;
            active_reg <= 1'b0;
        end else if (restart_req) begin
            sar_reg <= 10'h000;
            bit_reg <= MSB_INDEX;
            timer_reg <= 8'h00;
            chan_reg <= 4'h0;
            if ((enable_rise ? bus_req_in.wdata[MA_HW_TRIG] : hw_mode)) begin
                state_reg <= ST_WAIT_TRIG;
                active_reg <= 1'b0;
            end else begin
                state_reg <= ST_SAMPLE;
                active_reg <= 1'b1;
            end
        end else if (hw_trigger) begin
            state_reg <= ST_TRIG_DELAY;
            sar_reg <= 10'h000;
            bit_reg <= MSB_INDEX;
            timer_reg <= 8'h00;
            chan_reg <= 4'h0;
            active_reg <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: active_reg <= 1'b0;
                ST_WAIT_TRIG: active_reg <= 1'b0;
                ST_TRIG_DELAY: begin
                    timer_reg <= timer_reg + 8'h01;
                    if (delay_done) begin
                        timer_reg <= 8'h00;
                        state_reg <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    timer_reg <= timer_reg + 8'h01;
                    if (sample_done) begin
                        timer_reg <= 8'h00;
                        state_reg <= ST_TRIAL;
                        sar_reg <= 10'h200;
                        bit_reg <= MSB_INDEX;
                    end
                end
                ST_TRIAL: begin
                    timer_reg <= timer_reg + 8'h01;
                    if (trial_done) begin
                        timer_reg <= 8'h00;
                        if (bit_reg != 4'h0) begin
                            sar_reg <= sar_final | (10'h001 << (bit_reg - 4'h1));
                            bit_reg <= bit_reg - 4'h1;
                        end else begin
                            sar_reg <= 10'h000;
                            bit_reg <= MSB_INDEX;
                            if (!last_of_sweep) begin
                                chan_reg <= chan_reg + 4'h1;
                                state_reg <= ST_SAMPLE;
                            end else if (hw_mode) begin
                                chan_reg <= 4'h0;
                                state_reg <= ST_WAIT_TRIG;
                                active_reg <= 1'b0;
                            end else if (one_shot) begin
                                state_reg <= ST_IDLE;
                                active_reg <= 1'b0;
                            end else begin
                                chan_reg <= 4'h0;
                                state_reg <= ST_SAMPLE;
                            end
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Result storage
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                result_mem[i] <= 10'h000;
            end
        end else if (store_en) begin
            result_mem[conv_chan] <= sar_final;
        end
    end

    // Conversion-end interrupt pulse
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= conv_done && !ctrl_write && !hw_trigger &&
                       last_of_sweep && cmp_pass;
        end
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rdata_reg <= 8'h00;
        end else if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                ADDR_MODE_A: rdata_reg <= {mode_reg_a_reg[7], active_reg, mode_reg_a_reg[5:0]};
                ADDR_MODE_B: rdata_reg <= mode_reg_b_reg;
                ADDR_TRIG_SRC: rdata_reg <= trigger_source_reg;
                ADDR_CHAN_SEL: rdata_reg <= channel_select_reg;
                ADDR_CMP_MODE: rdata_reg <= compare_mode_reg;
                ADDR_CMP_THRESH: rdata_reg <= compare_threshold_reg;
                ADDR_RESULT_IDX: rdata_reg <= {4'h0, result_idx_reg};
                ADDR_RESULT_LO: rdata_reg <= {result_mem[rd_idx][1:0], 6'h00};
                ADDR_RESULT_HI: rdata_reg <= result_mem[rd_idx][9:2];
                ADDR_RESULT_BYTE: rdata_reg <= result_mem[rd_idx][9:2];
                ADDR_STATUS: rdata_reg <= {3'h0, active_reg, chan_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign bus_rdata_out = rdata_reg;
    assign conv_end_irq_out = irq_reg;
    assign analog_out.sample = (state_reg == ST_SAMPLE);
    assign analog_out.hold = (state_reg == ST_TRIAL);
    assign analog_out.channel = conv_chan;
    assign analog_out.dac_code = sar_reg;
endmodule
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sas_pkg::*;
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
    logic sys_clk_in = 1'b0;
    logic reset_in, pin, comparator, conv_end_irq_out, idle;
    logic rd_d = 1'b0;
    logic samp_d = 1'b0;
    logic [1:0] tmr;
    logic [7:0] bus_rdata_out, thr;
    logic [9:0] base;
    logic [15:0] note;
    logic [15:0] exp_q[$];
    sas_bus_req_type bus_req;
    sas_analog_type analog_out;
    int error_cnt = 0;
    int check_count = 0;
    int irq_cnt = 0;
    int cyc = 0;
    int samp_t = 0;
    int t0, n, i, seed;
    always #2.5 sys_clk_in = ~sys_clk_in;
    sas_sequencer sas_sequencer_i (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .bus_req_in(bus_req),
        .bus_rdata_out(bus_rdata_out),
        .ext_trigger_pin_in(pin),
        .timer_match0_req_in(tmr[0]),
        .timer_match1_req_in(tmr[1]),
        .comparator_in(comparator),
        .analog_out(analog_out),
        .conv_end_irq_out(conv_end_irq_out)
    );
    sas_analog_model sas_analog_model_i (
        .sys_clk_in(sys_clk_in),
        .analog_in(analog_out),
        .base_in(base),
        .comparator_out(comparator)
    );
    // Output watcher: read answers, interrupts, sampling start
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (conv_end_irq_out === 1'b1) irq_cnt <= irq_cnt + 1;
        if (analog_out.sample === 1'b1 && samp_d == 1'b0) samp_t <= cyc;
        samp_d <= analog_out.sample;
        if (rd_d) begin
            note = exp_q.pop_front();
            `CHK("rdata", note[7:0], bus_rdata_out & note[15:8])
        end
        rd_d <= bus_req.rd;
    end
    function automatic logic [9:0] vin(input logic [3:0] ch);
        return base + 10'(ch) * 10'h047;
    endfunction
    function automatic logic [7:0] mode(input logic [1:0] op, input logic [1:0] edg,
                                        input logic hw);
        return {1'b1, 1'b0, op, edg, 1'b0, hw};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back({m, e & m});
        @(posedge sys_clk_in);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        bus_req <= '0;
    endtask
    task automatic start(input logic [3:0] ch, input logic [1:0] src, input logic [7:0] m);
        wr(ADDR_MODE_A, 8'h00);
        wr(ADDR_CHAN_SEL, {4'h0, ch});
        wr(ADDR_TRIG_SRC, {6'h00, src});
        wr(ADDR_MODE_A, m);
        t0 = cyc;
    endtask
    task automatic res(input logic [3:0] ch);
        logic [9:0] v;
        v = vin(ch);
        wr(ADDR_RESULT_IDX, {4'h0, ch});
        rd(ADDR_RESULT_HI, 8'hFF, v[9:2]);
        rd(ADDR_RESULT_LO, 8'hFF, {v[1:0], 6'h00});
        rd(ADDR_RESULT_BYTE, 8'hFF, v[9:2]);
    endtask
    task automatic wait_irq(input int cnt);
        int k;
        k = 0;
        while (irq_cnt < cnt && k < 2000) begin
            @(posedge sys_clk_in);
            k++;
        end
        `CHK("irq_wait", 1'b1, irq_cnt >= cnt)
    endtask
    task automatic wait_hold;
        int k;
        k = 0;
        while (analog_out.hold !== 1'b1 && k < 1000) begin
            @(posedge sys_clk_in);
            k++;
        end
        repeat (30) @(posedge sys_clk_in);
    endtask
    task automatic pulse(input logic [1:0] m);
        tmr <= m;
        repeat (4) @(posedge sys_clk_in);
        tmr <= 2'b00;
    endtask
    task end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        error_cnt++;
        end_sim;
    end
    initial begin
        seed = 32'h9aa962b0;
        reset_in = 1'b1;
        bus_req = '0;
        pin = 1'b0;
        tmr = 2'b00;
        base = 10'($random(seed));
        thr = 8'($random(seed));
        repeat (10) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        rd(ADDR_CMP_THRESH, 8'hFF, REG_RESET);
        wr(ADDR_CMP_THRESH, thr);
        rd(ADDR_CMP_THRESH, 8'hFF, thr);
        rd(4'hF, 8'hFF, 8'h00);
        start(4'h3, SRC_EXT_PIN, mode(OP_ONE_SELECT, EDGE_FALL, 1'b0));
        rd(ADDR_MODE_A, 8'h40, 8'h40);
        wait_irq(1);
        `CHK("sw_delay", 1'b1, samp_t - t0 <= 2)
        rd(ADDR_MODE_A, 8'hC0, 8'h00);
        res(4'h3);
        start(4'h2, SRC_EXT_PIN, mode(OP_ONE_SCAN, EDGE_FALL, 1'b0));
        rd(ADDR_STATUS, 8'hFF, 8'h10);
        repeat (1200) @(posedge sys_clk_in);
        `CHK("scan_irq", 2, irq_cnt)
        for (i = 0; i < 3; i++) res(4'(i));
        n = irq_cnt;
        start(4'h1, SRC_EXT_PIN, mode(OP_CONT_SCAN, EDGE_FALL, 1'b0));
        wait_irq(n + 2);
        rd(ADDR_MODE_A, 8'hC0, 8'hC0);
        wait_hold;
        wr(ADDR_MODE_A, 8'h00);
        res(4'h1);
        for (i = 0; i < 2; i++) begin
            n = irq_cnt;
            wr(ADDR_CMP_THRESH, 8'(vin(4'h0) >> 2));
            wr(ADDR_CMP_MODE, {1'b1, i[0], 6'h00});
            start(4'h0, SRC_EXT_PIN, mode(OP_ONE_SELECT, EDGE_FALL, 1'b0));
            repeat (400) @(posedge sys_clk_in);
            `CHK("cmp_irq", n + 1 - i, irq_cnt)
        end
        wr(ADDR_CMP_MODE, 8'h00);
        n = irq_cnt;
        start(4'h1, SRC_EXT_PIN, mode(OP_CONT_SELECT, EDGE_FALL, 1'b0));
        wait_hold;
        t0 = cyc;
        wr(ADDR_CMP_THRESH, 8'h00);
        wait_irq(n + 1);
        `CHK("restart", 1'b1, cyc - t0 >= SAMPLE_CYCLES + 10 * TRIAL_CYCLES)
        wait_irq(n + 2);
        wait_hold;
        wr(ADDR_MODE_A, 8'h00);
        res(4'h1);
        for (i = 0; i < 3; i++) begin
            idle = (i == 0);
            pin <= idle;
            start(4'h1, SRC_EXT_PIN, mode(OP_ONE_SELECT, 2'(i), 1'b1));
            repeat (20) @(posedge sys_clk_in);
            rd(ADDR_MODE_A, 8'h40, 8'h00);
            n = irq_cnt;
            t0 = cyc;
            pin <= ~idle;
            wait_irq(n + 1);
            `CHK("hw_delay", 1'b1, samp_t - t0 >= TRIG_DELAY_CYCLES + 2)
            rd(ADDR_MODE_A, 8'hC0, 8'h80);
            if (i == 2) begin
                pin <= idle;
                wait_irq(n + 2);
            end
        end
        start(4'h2, SRC_TIMER0, mode(OP_ONE_SELECT, EDGE_FALL, 1'b1));
        repeat (20) @(posedge sys_clk_in);
        n = irq_cnt;
        pulse(2'b01);
        wait_hold;
        t0 = cyc;
        pulse(2'b01);
        wait_irq(n + 1);
        `CHK("retrigger", 1'b1, cyc - t0 >= SAMPLE_CYCLES + 10 * TRIAL_CYCLES)
        repeat (400) @(posedge sys_clk_in);
        `CHK("standby_irq", n + 1, irq_cnt)
        res(4'h2);
        start(4'h0, SRC_TIMER1, mode(OP_CONT_SELECT, EDGE_FALL, 1'b1));
        repeat (20) @(posedge sys_clk_in);
        n = irq_cnt;
        pulse(2'b10);
        wait_hold;
        wr(ADDR_CMP_THRESH, 8'h00);
        repeat (400) @(posedge sys_clk_in);
        `CHK("abort_irq", n, irq_cnt)
        rd(ADDR_MODE_A, 8'hC0, 8'h80);
        wr(ADDR_MODE_A, 8'h00);
        end_sim;
    end
endmodule
`default_nettype wire
